// >>> common/rvsp_pkg.sv
// constants shared by both ends of the reference level serial program port
package rvsp_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_NS = 25;
  localparam int SYS_HZ = 40_000_000;
  localparam int SCLK_MIN_NS = 200;
  localparam int SCLK_HALF_CYC = (SCLK_MIN_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int OSC_HZ = 21_000;
  localparam int OSC_HALF_CYC = SYS_HZ / (2 * OSC_HZ);
  localparam int SYNC_STAGES = 3;
  // ----------------------------------------
  // word layout
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam int BIT_TEST = 15;
  localparam int BIT_SRC = 14;
  localparam int CH_HI = 13;
  localparam int CH_LO = 10;
  localparam int CH_W = CH_HI - CH_LO + 1;
  localparam int LVL_HI = 9;
  localparam int LVL_W = LVL_HI + 1;
  localparam int NUM_CH = 10;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic SRC_RST = 1'b0;
  localparam logic [LVL_W-1:0] LEVEL_RST = 10'h000;
  localparam logic [3:0] SYNC_RST = 4'h1;
endpackage

// >>> common/rvsp_if.sv
// four-wire link plus two-way refresh clock pin
`timescale 1ns/1ps
`default_nettype none
interface rvsp_if;
  logic chip_select_n;
  logic shift_clk;
  logic serial_in_line;
  logic chain_out_line;
  logic refresh_clk_o;
  logic refresh_clk_oe;
  logic refresh_ext_o;
  logic refresh_clock_pin;
  // pin level: device drive wins, else the outside source
  assign refresh_clock_pin = refresh_clk_oe ? refresh_clk_o : refresh_ext_o;
  modport host (
    output chip_select_n,
    output shift_clk,
    output serial_in_line,
    input chain_out_line
  );
  modport device (
    input chip_select_n,
    input shift_clk,
    input serial_in_line,
    output chain_out_line,
    output refresh_clk_o,
    output refresh_clk_oe,
    input refresh_clock_pin
  );
endinterface
`default_nettype wire

// >>> logic/rvsp_device.sv
// device end: shift register, channel levels and refresh scan
`timescale 1ns/1ps
`default_nettype none
module rvsp_device (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // link
  rvsp_if.device link,
  // programmed state
  output logic [rvsp_pkg::NUM_CH*rvsp_pkg::LVL_W-1:0] o_level,
  output logic o_refresh_ext,
  output logic o_word_strobe,
  output logic [rvsp_pkg::CH_W-1:0] o_refresh_slot
);

  // ----------------------------------------
  // channel decode
  // ----------------------------------------
  function automatic logic [rvsp_pkg::CH_W-1:0] ch_of(input logic [rvsp_pkg::WORD_W-1:0] w);
    ch_of = w[rvsp_pkg::CH_HI:rvsp_pkg::CH_LO];
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // bit 0 select, 1 shift clock, 2 data, 3 refresh pin
  logic [3:0] pin_raw;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] st_q;
  logic [3:0] prev_q;

  assign pin_raw = {link.refresh_clock_pin, link.serial_in_line, link.shift_clk, link.chip_select_n};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          s1_q[gi] <= rvsp_pkg::SYNC_RST[gi];
          s2_q[gi] <= rvsp_pkg::SYNC_RST[gi];
          s3_q[gi] <= rvsp_pkg::SYNC_RST[gi];
          st_q[gi] <= rvsp_pkg::SYNC_RST[gi];
          prev_q[gi] <= rvsp_pkg::SYNC_RST[gi];
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            st_q[gi] <= s3_q[gi];
          end
          prev_q[gi] <= st_q[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // link events, clock edges gated by select
  // ----------------------------------------
  logic sel_low;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;

  assign sel_low = ~st_q[0];
  assign sclk_rise = sel_low & st_q[1] & ~prev_q[1];
  assign sclk_fall = sel_low & ~st_q[1] & prev_q[1];
  assign cs_rise = st_q[0] & ~prev_q[0];

  // ----------------------------------------
  // shift register
  // ----------------------------------------
  logic [rvsp_pkg::WORD_W-1:0] shift_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      shift_q <= '0;
    end else if (sclk_rise) begin
      // newest bit enters at the bottom, oldest leaves the top
      shift_q <= {shift_q[rvsp_pkg::WORD_W-2:0], st_q[2]};
    end
  end

  // ----------------------------------------
  // chain output
  // ----------------------------------------
  logic chain_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      chain_q <= 1'b0;
    end else if (sclk_fall) begin
      chain_q <= shift_q[rvsp_pkg::WORD_W-1];
    end
  end

  assign link.chain_out_line = chain_q;

  // ----------------------------------------
  // word latch on select release
  // ----------------------------------------
  logic src_q;
  logic programmed_q;
  logic strobe_q;
  logic [rvsp_pkg::LVL_W-1:0] level_q [rvsp_pkg::NUM_CH];
  logic [rvsp_pkg::CH_W-1:0] wr_ch;

  assign wr_ch = ch_of(shift_q);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      src_q <= rvsp_pkg::SRC_RST;
      programmed_q <= 1'b0;
    end else if (cs_rise) begin
      src_q <= shift_q[rvsp_pkg::BIT_SRC];
      programmed_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= cs_rise;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      for (int i = 0; i < rvsp_pkg::NUM_CH; i++) begin
        level_q[i] <= rvsp_pkg::LEVEL_RST;
      end
    end else if (cs_rise && (wr_ch < rvsp_pkg::CH_W'(rvsp_pkg::NUM_CH))) begin
      // channel numbers past the last one are dropped
      level_q[wr_ch] <= shift_q[rvsp_pkg::LVL_HI:0];
    end
  end

  // ----------------------------------------
  // internal refresh oscillator
  // ----------------------------------------
  localparam int OSC_W = $clog2(rvsp_pkg::OSC_HALF_CYC);
  logic [OSC_W-1:0] osc_cnt_q;
  logic osc_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      osc_cnt_q <= '0;
      osc_q <= 1'b0;
    end else if (osc_cnt_q == OSC_W'(rvsp_pkg::OSC_HALF_CYC - 1)) begin
      osc_cnt_q <= '0;
      osc_q <= ~osc_q;
    end else begin
      osc_cnt_q <= osc_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------
  // refresh clock pin
  // ----------------------------------------
  logic pin_o_q;
  logic pin_oe_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      pin_o_q <= osc_q;
      // drive only once a word has chosen the internal source
      pin_oe_q <= programmed_q & ~src_q;
    end
  end

  assign link.refresh_clk_o = pin_o_q;
  assign link.refresh_clk_oe = pin_oe_q;

  // ----------------------------------------
  // refresh scan
  // ----------------------------------------
  logic ref_clk;
  logic ref_prev_q;
  logic ref_fall;
  logic [rvsp_pkg::CH_W-1:0] slot_q;
  logic [rvsp_pkg::LVL_W-1:0] out_q [rvsp_pkg::NUM_CH];

  assign ref_clk = src_q ? st_q[3] : osc_q;
  assign ref_fall = ref_prev_q & ~ref_clk;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ref_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_clk;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      slot_q <= '0;
    end else if (ref_fall) begin
      if (slot_q == rvsp_pkg::CH_W'(rvsp_pkg::NUM_CH - 1)) begin
        slot_q <= '0;
      end else begin
        slot_q <= slot_q + 1'b1;
      end
    end
  end

  generate
    for (gi = 0; gi < rvsp_pkg::NUM_CH; gi++) begin : g_out
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          out_q[gi] <= rvsp_pkg::LEVEL_RST;
        end else if (ref_fall && (slot_q == rvsp_pkg::CH_W'(gi))) begin
          out_q[gi] <= level_q[gi];
        end
      end
      assign o_level[gi*rvsp_pkg::LVL_W +: rvsp_pkg::LVL_W] = out_q[gi];
    end
  endgenerate

  // ----------------------------------------
  // user outputs
  // ----------------------------------------
  assign o_refresh_ext = src_q;
  assign o_word_strobe = strobe_q;
  assign o_refresh_slot = slot_q;

endmodule
`default_nettype wire

// >>> logic/rvsp_host.sv
// host end: sends 16-bit words, optionally chained under one select
`timescale 1ns/1ps
`default_nettype none
module rvsp_host (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // word request
  input wire logic i_valid,
  input wire logic [rvsp_pkg::WORD_W-1:0] i_word,
  input wire logic i_last,
  output logic o_ready,
  output logic o_busy,
  output logic o_done,
  // link
  rvsp_if.host link
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LOW = 4'h2,
    ST_HIGH = 4'h4,
    ST_END = 4'h8
  } rvsp_state_t;

  localparam int TW = $clog2(rvsp_pkg::SCLK_HALF_CYC + 1);

  rvsp_state_t state_q;
  logic [TW-1:0] tmr_q;
  logic [3:0] cnt_q;
  logic [rvsp_pkg::WORD_W-1:0] sr_q;
  logic last_q;
  logic cs_q;
  logic sclk_q;
  logic sdi_q;
  logic ready_q;
  logic done_q;
  logic busy_q;
  logic tmr_end;
  logic take_next;

  assign tmr_end = (tmr_q == TW'(rvsp_pkg::SCLK_HALF_CYC - 1));
  assign take_next = (cnt_q == 4'hF) && !last_q && i_valid;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      tmr_q <= '0;
      cnt_q <= 4'h0;
      sr_q <= '0;
      last_q <= 1'b1;
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      sdi_q <= 1'b0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      ready_q <= 1'b0;
      done_q <= 1'b0;
      tmr_q <= tmr_end ? '0 : tmr_q + 1'b1;
      case (state_q)
        ST_IDLE: begin
          tmr_q <= '0;
          if (i_valid) begin
            // clock already low here
            cs_q <= 1'b0;
            busy_q <= 1'b1;
            sr_q <= {1'b0, i_word[rvsp_pkg::BIT_TEST-1:0]};
            sdi_q <= 1'b0;
            last_q <= i_last;
            cnt_q <= 4'h0;
            ready_q <= 1'b1;
            state_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (tmr_end) begin
            sclk_q <= 1'b1;
            state_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (tmr_end) begin
            sclk_q <= 1'b0;
            if (take_next) begin
              sr_q <= {1'b0, i_word[rvsp_pkg::BIT_TEST-1:0]};
              sdi_q <= 1'b0;
              last_q <= i_last;
              cnt_q <= 4'h0;
              ready_q <= 1'b1;
              state_q <= ST_LOW;
            end else if (cnt_q == 4'hF) begin
              state_q <= ST_END;
            end else begin
              sr_q <= {sr_q[rvsp_pkg::WORD_W-2:0], 1'b0};
              sdi_q <= sr_q[rvsp_pkg::WORD_W-2];
              cnt_q <= cnt_q + 1'b1;
              state_q <= ST_LOW;
            end
          end
        end
        ST_END: begin
          if (tmr_end) begin
            cs_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cs_q <= 1'b1;
          busy_q <= 1'b0;
          sclk_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link.chip_select_n = cs_q;
  assign link.shift_clk = sclk_q;
  assign link.serial_in_line = sdi_q;
  assign o_ready = ready_q;
  assign o_done = done_q;
  assign o_busy = busy_q;

endmodule
`default_nettype wire

// >>> bench/rvsp_link_properties.sv
// concurrent checks on the link between host and device
`timescale 1ns/1ps
`default_nettype none
module rvsp_link_properties (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // link
  input wire logic chip_select_n,
  input wire logic shift_clk,
  input wire logic serial_in_line,
  input wire logic chain_out_line,
  input wire logic refresh_clk_o,
  input wire logic refresh_clk_oe
);
  // ----------------------------------------
  // rising shift clock count in the frame
  // ----------------------------------------
  logic [5:0] rises_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || chip_select_n) begin
      rises_q <= 6'h00;
    end else if ($rose(shift_clk)) begin
      rises_q <= rises_q + 6'h01;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_clk_low_start: assert property ($fell(chip_select_n) |-> !shift_clk)
    else $error("shift clock high when select fell");
  a_whole_words: assert property ($rose(chip_select_n) |-> rises_q != 6'h00 && rises_q[3:0] == 4'h0)
    else $error("frame not a whole number of words");
  a_end_clk_low: assert property ($rose(chip_select_n) |-> !shift_clk && !$past(shift_clk, 3))
    else $error("select rose too close to a clock edge");
  a_test_bit_zero: assert property ($rose(shift_clk) && !chip_select_n && rises_q[3:0] == 4'h0 |-> !serial_in_line)
    else $error("test bit sent as one");
  a_clk_high_width: assert property ($rose(shift_clk) |-> shift_clk [*4])
    else $error("shift clock high phase too short");
  a_clk_low_width: assert property ($fell(shift_clk) |-> !shift_clk [*4])
    else $error("shift clock low phase too short");
  a_data_hold: assert property ($rose(shift_clk) |-> $stable(serial_in_line) [*4])
    else $error("serial data moved around a rising clock");
  a_chain_quiet: assert property (chip_select_n && $past(chip_select_n, 8) |-> $stable(chain_out_line))
    else $error("chain output moved while deselected");
  a_chain_on_fall: assert property ($changed(chain_out_line) |-> $past(shift_clk, 6) &&
    !$past(shift_clk, 5) && !$past(chip_select_n, 6))
    else $error("chain output moved outside a falling edge");
  a_oe_after_word: assert property ($rose(refresh_clk_oe) |-> chip_select_n && $past(chip_select_n, 4))
    else $error("refresh pin driven without a latched word");
  a_osc_half: assert property ($rose(refresh_clk_o) |-> refresh_clk_o [*8])
    else $error("refresh clock pulse too short");
  c_chained: cover property ($rose(chip_select_n) && rises_q == 6'h20);
  c_pin_out: cover property ($rose(refresh_clk_oe));
  c_pin_in: cover property ($fell(refresh_clk_oe));
endmodule
`default_nettype wire

// >>> bench/ref_voltage_serial_program_port_test.sv
// host and device face to face, plus a second device on a hand driven link
`timescale 1ns/1ps
`default_nettype none
module ref_voltage_serial_program_port_test;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_valid = 1'b0;
  logic [rvsp_pkg::WORD_W-1:0] i_word = 16'h0000;
  logic i_last = 1'b1;
  logic ext_clk = 1'b0;
  logic o_ready, o_busy, o_done, o_refresh_ext, o_word_strobe, ext2, strobe2;
  logic [rvsp_pkg::NUM_CH*rvsp_pkg::LVL_W-1:0] o_level, level2;
  logic [rvsp_pkg::CH_W-1:0] o_refresh_slot;
  logic [3:0] ev;
  logic [9:0] exp_lv [10];
  logic exp_ext;
  logic sent [$];
  logic cs_prev = 1'b1;
  logic sclk_prev = 1'b0;
  int nf, n_str2, n_errors, checks_done;
  integer seed;
  rvsp_if link();
  rvsp_if link2();
  assign link.refresh_ext_o = ext_clk;
  assign link2.refresh_ext_o = ext_clk;
  assign ev = {strobe2, o_word_strobe, o_done, o_ready};
  always #12.5 i_clk_sys = ~i_clk_sys;
  always #200 ext_clk = ~ext_clk;
  rvsp_host u_rvsp_host (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_valid(i_valid), .i_word(i_word),
    .i_last(i_last), .o_ready(o_ready), .o_busy(o_busy), .o_done(o_done), .link(link.host));
  rvsp_device u_rvsp_device (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .link(link.device), .o_level(o_level),
    .o_refresh_ext(o_refresh_ext), .o_word_strobe(o_word_strobe), .o_refresh_slot(o_refresh_slot));
  rvsp_device u_rvsp_device_b (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .link(link2.device), .o_level(level2),
    .o_refresh_ext(ext2), .o_word_strobe(strobe2), .o_refresh_slot());
  rvsp_link_properties u_rvsp_link_properties (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .chip_select_n(link.chip_select_n), .shift_clk(link.shift_clk), .serial_in_line(link.serial_in_line),
    .chain_out_line(link.chain_out_line), .refresh_clk_o(link.refresh_clk_o),
    .refresh_clk_oe(link.refresh_clk_oe));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wait_for(input int i);
    int k;
    k = 0;
    do begin
      @(posedge i_clk_sys);
      k++;
    end while (ev[i] !== 1'b1 && k < 400);
    check(16'(k < 400), 16'h0001);
  endtask
  task automatic check_levels(input logic [rvsp_pkg::NUM_CH*rvsp_pkg::LVL_W-1:0] lv, input int ch, input int want);
    check(16'(lv[ch*rvsp_pkg::LVL_W +: rvsp_pkg::LVL_W]), 16'(want));
  endtask
  // bit k of a word as it must travel, test bit forced to zero
  function automatic logic exp_bit(input logic [15:0] w, input int k);
    logic [15:0] t;
    t = w;
    t[rvsp_pkg::BIT_TEST] = 1'b0;
    return t[15 - k];
  endfunction
  task automatic send(input logic [15:0] a, input logic [15:0] b, input bit two);
    int k;
    logic [15:0] v;
    i_valid <= 1'b1;
    i_word <= a;
    i_last <= !two;
    wait_for(0);
    check(16'(o_busy), 16'h0001);
    if (two) begin
      i_word <= b;
      i_last <= 1'b1;
      wait_for(0);
    end
    i_valid <= 1'b0;
    wait_for(1);
    check(16'(o_busy), 16'h0000);
    check(16'(sent.size()), two ? 16'h0020 : 16'h0010);
    for (k = 0; k < (two ? 32 : 16); k++) begin
      check(16'(sent[k]), 16'(exp_bit((k < 16) ? a : b, k % 16)));
    end
    v = two ? b : a;
    if (v[13:10] < 4'hA) exp_lv[v[13:10]] = v[9:0];
    exp_ext = v[14];
    wait_for(2);
    repeat (3) @(posedge i_clk_sys);
    check(16'(o_refresh_ext), 16'(exp_ext));
    check(16'(link.refresh_clk_oe), 16'(!exp_ext));
    if (exp_ext) begin
      repeat (200) @(posedge i_clk_sys);
      for (k = 0; k < 10; k++) check_levels(o_level, k, exp_lv[k]);
      check(16'(o_refresh_slot < 4'hA), 16'h0001);
    end
  endtask
  task automatic pulse2(input logic b);
    link2.serial_in_line <= b;
    repeat (4) @(posedge i_clk_sys);
    link2.shift_clk <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    link2.shift_clk <= 1'b0;
  endtask
  task automatic frame2(input logic [15:0] w, input int n);
    int i;
    link2.chip_select_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    for (i = n - 1; i >= 0; i--) pulse2(w[i]);
    repeat (4) @(posedge i_clk_sys);
    link2.chip_select_n <= 1'b1;
    wait_for(3);
    repeat (200) @(posedge i_clk_sys);
  endtask
  // ----------------------------------------
  // chain output monitor
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (cs_prev === 1'b1 && link.chip_select_n === 1'b0) begin
      sent.delete();
      nf = 0;
    end
    if (link.chip_select_n === 1'b0 && sclk_prev === 1'b0 && link.shift_clk === 1'b1) sent.push_back(link.serial_in_line);
    if (link.chip_select_n === 1'b0 && sclk_prev === 1'b1 && link.shift_clk === 1'b0) begin
      if (nf >= 16) check(16'(link.chain_out_line), 16'(sent[nf - 16]));
      nf++;
    end
    cs_prev <= link.chip_select_n;
    sclk_prev <= link.shift_clk;
  end
  always @(posedge i_clk_sys) if (strobe2 === 1'b1) n_str2++;
  initial begin
    #1000000;
    n_errors++;
    give_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic [15:0] w;
    int k;
    seed = 32'h062f;
    link2.chip_select_n = 1'b1;
    link2.shift_clk = 1'b0;
    link2.serial_in_line = 1'b0;
    for (k = 0; k < 10; k++) exp_lv[k] = 10'h000;
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    check(16'(link.refresh_clk_oe), 16'h0000);
    check(16'(o_refresh_ext), 16'h0000);
    send(16'h43FF, 16'h0000, 1'b0);
    send(16'h6400, 16'h0000, 1'b0);
    send(16'h7FFF, 16'h0000, 1'b0);
    send(16'hC201, 16'h0000, 1'b0);
    send(16'h0A05, 16'h0000, 1'b0);
    send(16'h1C1F, 16'h5D55, 1'b1);
    repeat (16) begin
      r = $random(seed);
      send(r[15:0], r[31:16], r[3] ^ r[20]);
    end
    for (k = 0; k < 16; k++) pulse2(1'($random(seed)));
    repeat (20) @(posedge i_clk_sys);
    check(16'(n_str2), 16'h0000);
    check(16'(link2.chain_out_line), 16'h0000);
    frame2(16'h4C55, 16);
    check_levels(level2, 3, 10'h055);
    w = {8'h55, 8'hA7};
    frame2(16'h00A7, 8);
    check_levels(level2, w[13:10], w[9:0]);
    check(16'(n_str2), 16'h0002);
    check(16'(ext2), 16'(w[14]));
    give_verdict();
  end
endmodule
`default_nettype wire
